// >>> alarm_cfg.svh
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_THR1       7'h20
`define ADDR_THR2       7'h22
`define ADDR_CNT1       7'h24
`define ADDR_CNT2       7'h26
`define ADDR_CTRL       7'h28
`define ADDR_DIAG       7'h3C
// ----------------------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------------------
`define RST_WORD        16'h0000
`define THR_MASK        16'hBFFF
`define CNT_MASK        16'h00FF
`define CTRL_MASK       16'hFF17
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define THR_SENSE_BIT   15
`define THR_VAL_MSB     13
`define CNT_MSB         7
`define CTRL_RATE2_BIT  15
`define CTRL_SRC2_MSB   14
`define CTRL_SRC2_LSB   12
`define CTRL_RATE1_BIT  11
`define CTRL_SRC1_MSB   10
`define CTRL_SRC1_LSB   8
`define CTRL_FILT_BIT   4
`define CTRL_OUT_EN_BIT 2
`define CTRL_POL_BIT    1
`define CTRL_LINE_BIT   0
`define DIAG_A2_BIT     9
`define DIAG_A1_BIT     8
`endif

// >>> alarm_pkg.sv
package alarm_pkg;
   typedef logic [13:0] sample_t;
   typedef logic [15:0] reg_word_t;
   typedef logic [7:0]  count_t;
   typedef enum logic [2:0] {
      SRC_OFF    = 3'h0,
      SRC_SUPPLY = 3'h1,
      SRC_RATE   = 3'h2,
      SRC_AUX    = 3'h5,
      SRC_TEMP   = 3'h6
   } alarm_src_t;
endpackage : alarm_pkg

// >>> alarm_ch_if.sv
`timescale 1ns/1ps
interface alarm_ch_if;
   import alarm_pkg::*;
   logic    sample_tick;
   logic    enabled;
   logic    rate_mode;
   logic    sense_gt;
   logic    is_signed;
   sample_t thr;
   count_t  count;
   sample_t cur;
   logic    alarm;
   modport ctrl (output sample_tick, enabled, rate_mode, sense_gt, is_signed, thr, count, cur,
                 input  alarm);
   modport chan (input  sample_tick, enabled, rate_mode, sense_gt, is_signed, thr, count, cur,
                 output alarm);
endinterface : alarm_ch_if

// >>> alarm_channel.sv
`timescale 1ns/1ps
module alarm_channel import alarm_pkg::*; (
   // Clock and reset
   input  wire logic  core_clk_in,
   input  wire logic  rst_n_in,
   // Configuration, sample and result
   alarm_ch_if.chan   ch
);
   // ----------------------------------------------------------------------------
   // History of past samples for rate-of-change
   // ----------------------------------------------------------------------------
   sample_t        hist [0:255];
   count_t         wptr_r, wptr_nxt;
   count_t         fill_r, fill_nxt;
   logic           alarm_r, alarm_nxt;
   count_t         n_w;
   count_t         rd_idx;
   logic [14:0]    cur_x, past_x, thr_x, diff, mag;
   logic           gt, lt, hit, ready;

   assign n_w    = (ch.count == 8'h00) ? 8'h01 : ch.count;
   assign rd_idx = wptr_r - n_w;
   assign cur_x  = {ch.is_signed & ch.cur[13], ch.cur};
   assign past_x = {ch.is_signed & hist[rd_idx][13], hist[rd_idx]};
   assign thr_x  = {ch.is_signed & ch.thr[13], ch.thr};
   assign diff   = cur_x - past_x;
   assign mag    = diff[14] ? 15'(-diff) : diff;
   assign ready  = (fill_r >= n_w);

   // Rate mode compares the size of the change, so both directions count.
   always_comb begin
      if (ch.rate_mode) begin
         gt = mag > {1'b0, ch.thr};
         lt = mag < {1'b0, ch.thr};
      end else begin
         gt = $signed(cur_x) > $signed(thr_x);
         lt = $signed(cur_x) < $signed(thr_x);
      end
      hit = ch.sense_gt ? gt : lt;
   end

   always_comb begin
      wptr_nxt  = wptr_r;
      fill_nxt  = fill_r;
      alarm_nxt = alarm_r;
      if (ch.sample_tick) begin
         if (ch.enabled) begin
            wptr_nxt  = wptr_r + 8'h01;
            fill_nxt  = (fill_r == 8'hFF) ? fill_r : fill_r + 8'h01;
            alarm_nxt = ch.rate_mode ? (ready & hit) : hit;
         end else begin
            fill_nxt  = 8'h00;
            alarm_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wptr_r  <= 8'h00;
         fill_r  <= 8'h00;
         alarm_r <= 1'b0;
      end else begin
         wptr_r  <= wptr_nxt;
         fill_r  <= fill_nxt;
         alarm_r <= alarm_nxt;
      end
   end

   // The history holds no reset; the fill count keeps stale words out of use.
   always_ff @(posedge core_clk_in) begin
      if (ch.sample_tick && ch.enabled) begin
         hist[wptr_r] <= ch.cur;
      end
   end

   assign ch.alarm = alarm_r;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   AST_DISABLED_QUIET: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ch.sample_tick && !ch.enabled |=> !alarm_r) else $error("disabled alarm went active");
   AST_HOLD_BETWEEN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !ch.sample_tick |=> $stable(alarm_r)) else $error("alarm changed without a sample");
   AST_RATE_WAIT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ch.sample_tick && ch.enabled && ch.rate_mode && (fill_r < n_w) |=> !alarm_r)
      else $error("rate alarm before window filled");
   AST_LOW_SENSE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ch.sample_tick && ch.enabled && !ch.rate_mode && !ch.sense_gt && !ch.is_signed
      && (ch.cur < ch.thr) |=> alarm_r) else $error("below-threshold alarm missed");
endmodule : alarm_channel

// >>> alarm_indicator.sv
`timescale 1ns/1ps
module alarm_indicator (
   // Clock and reset
   input  wire logic  core_clk_in,
   input  wire logic  rst_n_in,
   // Alarm and indicator setup
   input  wire logic  any_alarm_in,
   input  wire logic  out_en_in,
   input  wire logic  active_high_in,
   input  wire logic  line_two_sel_in,
   // Digital lines
   output logic       line_one_out,
   output logic       line_one_oe_n_out,
   output logic       line_two_out,
   output logic       line_two_oe_n_out
);
   logic [3:0] pins_r, pins_nxt;
   logic       level;

   always_comb begin
      level    = active_high_in ? any_alarm_in : !any_alarm_in;
      pins_nxt = 4'hA;
      if (out_en_in) begin
         if (line_two_sel_in) begin
            pins_nxt = {1'b0, level, 1'b1, 1'b0};
         end else begin
            pins_nxt = {1'b1, 1'b0, 1'b0, level};
         end
      end
   end

   // Bit order is two_oe_n, two, one_oe_n, one; a released line stays low.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pins_r <= 4'hA;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign line_one_out      = pins_r[0];
   assign line_one_oe_n_out = pins_r[1];
   assign line_two_out      = pins_r[2];
   assign line_two_oe_n_out = pins_r[3];

   AST_LINES_FREE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !out_en_in |=> line_one_oe_n_out && line_two_oe_n_out) else $error("line driven while off");
   AST_LINE_SELECT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      out_en_in && line_two_sel_in |=> !line_two_oe_n_out && line_one_oe_n_out)
      else $error("wrong indicator line");
   AST_POLARITY: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      out_en_in && !line_two_sel_in |=>
      line_one_out == ($past(active_high_in) ~^ $past(any_alarm_in)))
      else $error("indicator polarity wrong");
endmodule : alarm_indicator

// >>> dual_alarm_monitor.sv
`timescale 1ns/1ps
`include "alarm_cfg.svh"
//
// Contract
// - Two alarm channels work independently
// - Rate window spans count times sample period
// - Threshold bit 15 picks above or below
// - Threshold low fourteen bits, bit 14 unused
// - Sample count low byte, zero means one
// - Control bit 15 rate mode alarm two
// - Control 14:12 picks alarm two source
// - Control bit 11 rate mode alarm one
// - Control 10:8 picks alarm one source
// - Control bit 4 filtered data select
// - Control bit 2 enables indicator output
// - Control bit 1 sets indicator polarity
// - Control bit 0 picks indicator line
// - All alarm registers reset to zero
// - Status bits nine and eight show alarms
// - Status read clears, condition sets again
//
module dual_alarm_monitor import alarm_pkg::*; (
   // Clock and reset
   input  wire logic          core_clk_in,
   input  wire logic          rst_n_in,
   // Sample stream: index 0 supply, 1 rate, 2 auxiliary, 3 temperature
   input  wire logic          sample_tick_in,
   input  wire sample_t [3:0] src_raw_in,
   input  wire sample_t [3:0] src_filt_in,
   // Register byte write
   input  wire logic          wr_en_in,
   input  wire logic [6:0]    wr_addr_in,
   input  wire logic [7:0]    wr_data_in,
   // Register word read
   input  wire logic          rd_en_in,
   input  wire logic [6:0]    rd_addr_in,
   output logic [15:0]        rd_data_out,
   output logic               rd_valid_out,
   // Digital lines
   output logic               line_one_out,
   output logic               line_one_oe_n_out,
   output logic               line_two_out,
   output logic               line_two_oe_n_out
);
   // ----------------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------------
   // Returns {hit, slot}; slots 0..4 are the two thresholds, two counts, control.
   function automatic logic [3:0] reg_slot(input logic [6:0] addr);
      logic [6:0] word;
      word = {addr[6:1], 1'b0};
      case (word)
         `ADDR_THR1: reg_slot = 4'h8;
         `ADDR_THR2: reg_slot = 4'h9;
         `ADDR_CNT1: reg_slot = 4'hA;
         `ADDR_CNT2: reg_slot = 4'hB;
         `ADDR_CTRL: reg_slot = 4'hC;
         default:    reg_slot = 4'h0;
      endcase
   endfunction : reg_slot

   function automatic reg_word_t slot_mask(input logic [2:0] slot);
      case (slot)
         3'h0, 3'h1: slot_mask = `THR_MASK;
         3'h2, 3'h3: slot_mask = `CNT_MASK;
         default:    slot_mask = `CTRL_MASK;
      endcase
   endfunction : slot_mask

   // Returns {valid, input index}; unused codes act as disabled.
   function automatic logic [2:0] src_slot(input logic [2:0] code);
      case (code)
         SRC_SUPPLY: src_slot = 3'h4;
         SRC_RATE:   src_slot = 3'h5;
         SRC_AUX:    src_slot = 3'h6;
         SRC_TEMP:   src_slot = 3'h7;
         default:    src_slot = 3'h0;
      endcase
   endfunction : src_slot

   // ----------------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------------
   reg_word_t [4:0] cfg_r, cfg_nxt;
   logic [3:0]      wr_slot;
   reg_word_t       wr_word;
   reg_word_t       ctrl;

   assign ctrl    = cfg_r[4];
   assign wr_slot = reg_slot(wr_addr_in);

   // Writes arrive a byte at a time; odd addresses carry the upper byte.
   always_comb begin
      cfg_nxt = cfg_r;
      wr_word = cfg_r[wr_slot[2:0]];
      if (wr_en_in && wr_slot[3]) begin
         if (wr_addr_in[0]) begin
            wr_word[15:8] = wr_data_in;
         end else begin
            wr_word[7:0] = wr_data_in;
         end
         cfg_nxt[wr_slot[2:0]] = wr_word & slot_mask(wr_slot[2:0]);
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_r <= {5{`RST_WORD}};
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Alarm channels
   // ----------------------------------------------------------------------------
   logic [1:0] alarm_w;

   for (genvar g = 0; g < 2; g++) begin : gen_chan
      alarm_ch_if chan_if ();
      logic [2:0] src_code;
      logic [2:0] sel;

      assign src_code = (g == 1) ? ctrl[`CTRL_SRC2_MSB:`CTRL_SRC2_LSB]
                                 : ctrl[`CTRL_SRC1_MSB:`CTRL_SRC1_LSB];
      assign sel                 = src_slot(src_code);
      assign chan_if.sample_tick = sample_tick_in;
      assign chan_if.enabled     = sel[2];
      assign chan_if.rate_mode   = (g == 1) ? ctrl[`CTRL_RATE2_BIT]
                                            : ctrl[`CTRL_RATE1_BIT];
      assign chan_if.sense_gt    = cfg_r[g][`THR_SENSE_BIT];
      assign chan_if.is_signed   = sel[0];
      assign chan_if.thr         = cfg_r[g][`THR_VAL_MSB:0];
      assign chan_if.count       = cfg_r[2 + g][`CNT_MSB:0];
      assign chan_if.cur         = ctrl[`CTRL_FILT_BIT] ? src_filt_in[sel[1:0]]
                                                        : src_raw_in[sel[1:0]];
      assign alarm_w[g]          = chan_if.alarm;

      alarm_channel u_chan (
         .core_clk_in (core_clk_in),
         .rst_n_in    (rst_n_in),
         .ch          (chan_if.chan)
      );
   end

   // ----------------------------------------------------------------------------
   // Status flags and register reads
   // ----------------------------------------------------------------------------
   logic        tick_d_r, tick_d_nxt;
   logic [1:0]  flag_r, flag_nxt;
   logic [1:0]  flag_set;
   logic        diag_clr;
   logic [15:0] rd_data_r, rd_data_nxt;
   logic        rd_valid_r, rd_valid_nxt;
   logic [3:0]  rd_slot;

   assign rd_slot  = reg_slot(rd_addr_in);
   assign diag_clr = rd_en_in && ({rd_addr_in[6:1], 1'b0} == `ADDR_DIAG);

   // Flags follow the alarm one cycle after the sample; a set beats the read clear.
   always_comb begin
      tick_d_nxt   = sample_tick_in;
      flag_set     = tick_d_r ? alarm_w : 2'b00;
      flag_nxt     = (flag_r & {2{!diag_clr}}) | flag_set;
      rd_valid_nxt = rd_en_in;
      rd_data_nxt  = rd_data_r;
      if (rd_en_in) begin
         rd_data_nxt = 16'h0000;
         if (rd_slot[3]) begin
            rd_data_nxt = cfg_r[rd_slot[2:0]];
         end else if (diag_clr) begin
            rd_data_nxt[`DIAG_A2_BIT] = flag_r[1];
            rd_data_nxt[`DIAG_A1_BIT] = flag_r[0];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_d_r   <= 1'b0;
         flag_r     <= 2'b00;
         rd_data_r  <= 16'h0000;
         rd_valid_r <= 1'b0;
      end else begin
         tick_d_r   <= tick_d_nxt;
         flag_r     <= flag_nxt;
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   assign rd_data_out  = rd_data_r;
   assign rd_valid_out = rd_valid_r;

   // ----------------------------------------------------------------------------
   // Indicator output
   // ----------------------------------------------------------------------------
   alarm_indicator u_ind (
      .core_clk_in       (core_clk_in),
      .rst_n_in          (rst_n_in),
      .any_alarm_in      (|alarm_w),
      .out_en_in         (ctrl[`CTRL_OUT_EN_BIT]),
      .active_high_in    (ctrl[`CTRL_POL_BIT]),
      .line_two_sel_in   (ctrl[`CTRL_LINE_BIT]),
      .line_one_out      (line_one_out),
      .line_one_oe_n_out (line_one_oe_n_out),
      .line_two_out      (line_two_out),
      .line_two_oe_n_out (line_two_oe_n_out)
   );

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   AST_STATUS_READ: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      diag_clr |=> rd_valid_out && rd_data_out[`DIAG_A1_BIT] == $past(flag_r[0])
      && rd_data_out[`DIAG_A2_BIT] == $past(flag_r[1]))
      else $error("status read data wrong");
   AST_READ_CLEARS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      diag_clr && !tick_d_r |=> flag_r == 2'b00) else $error("status flags not cleared");
   AST_FLAG_RETURNS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      tick_d_r && alarm_w[1] |=> flag_r[1]) else $error("active alarm lost its flag");
   AST_SPARE_BITS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !cfg_r[0][14] && !cfg_r[1][14] && cfg_r[2][15:8] == 8'h00 && cfg_r[3][15:8] == 8'h00
      && cfg_r[4][7:5] == 3'h0 && cfg_r[4][3] == 1'b0)
      else $error("unused register bit set");
   AST_CTRL_READBACK: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      rd_en_in && ({rd_addr_in[6:1], 1'b0} == `ADDR_CTRL) |=> rd_data_out == $past(ctrl))
      else $error("control readback wrong");
endmodule : dual_alarm_monitor

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic        core_clk_in,
   // Register access towards the device
   output logic             wr_en_out,
   output logic [6:0]       wr_addr_out,
   output logic [7:0]       wr_data_out,
   output logic             rd_en_out,
   output logic [6:0]       rd_addr_out,
   input  wire logic [15:0] rd_data_in,
   input  wire logic        rd_valid_in
);
   initial begin
      wr_en_out   = 1'b0;
      wr_addr_out = 7'h00;
      wr_data_out = 8'h00;
      rd_en_out   = 1'b0;
      rd_addr_out = 7'h00;
   end
   // -------------------------------------------------------------------------
   // Word write, high byte first, one byte per cycle as a serial host sends.
   // -------------------------------------------------------------------------
   task automatic wr_word(input logic [6:0] addr, input logic [15:0] data);
      @(posedge core_clk_in);
      #2;
      wr_en_out   = 1'b1;
      wr_addr_out = addr | 7'h01;
      wr_data_out = data[15:8];
      @(posedge core_clk_in);
      #2;
      wr_addr_out = addr;
      wr_data_out = data[7:0];
      @(posedge core_clk_in);
      #2;
      wr_en_out   = 1'b0;
      // Released lines show a changed pattern so stale data is never mistaken.
      wr_addr_out = ~addr;
      wr_data_out = ~data[7:0];
   endtask : wr_word
   // -------------------------------------------------------------------------
   // Word read; ok stays low if no valid answer arrives within the bound.
   // -------------------------------------------------------------------------
   task automatic rd_word(input logic [6:0] addr, output logic [15:0] data, output logic ok);
      int n;
      ok   = 1'b0;
      data = 16'h0000;
      @(posedge core_clk_in);
      #2;
      rd_en_out   = 1'b1;
      rd_addr_out = addr;
      @(posedge core_clk_in);
      #2;
      rd_en_out   = 1'b0;
      rd_addr_out = ~addr;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rd_valid_in === 1'b1) begin
            data = rd_data_in;
            ok   = 1'b1;
         end else begin
            @(posedge core_clk_in);
            #2;
         end
      end
   endtask : rd_word
endmodule : host_model

// >>> tb_top.sv
`timescale 1ns/1ps
`include "alarm_cfg.svh"
module tb_top import alarm_pkg::*;;
   logic          core_clk = 1'b0;
   logic          rst_n    = 1'b0;
   logic          tick     = 1'b0;
   sample_t [3:0] raw      = '0;
   sample_t [3:0] filt     = '0;
   logic          wr_en, rd_en, rd_valid;
   logic [6:0]    wr_addr, rd_addr;
   logic [7:0]    wr_data;
   logic [15:0]   rd_data;
   logic          l1, l1_oe_n, l2, l2_oe_n;
   int            mismatches = 0;
   int            n_checks   = 0;
   logic [6:0]    regs [5] = '{`ADDR_THR1, `ADDR_THR2, `ADDR_CNT1, `ADDR_CNT2, `ADDR_CTRL};
   logic [15:0]   masks[5] = '{16'hBFFF, 16'hBFFF, 16'h00FF, 16'h00FF, 16'hFF17};
   always #12.5 core_clk = ~core_clk;
   dual_alarm_monitor dual_alarm_monitor_inst (
      .core_clk_in(core_clk), .rst_n_in(rst_n), .sample_tick_in(tick),
      .src_raw_in(raw), .src_filt_in(filt), .wr_en_in(wr_en), .wr_addr_in(wr_addr),
      .wr_data_in(wr_data), .rd_en_in(rd_en), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .line_one_out(l1), .line_one_oe_n_out(l1_oe_n),
      .line_two_out(l2), .line_two_oe_n_out(l2_oe_n));
   host_model host_model_inst (
      .core_clk_in(core_clk), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
      .wr_data_out(wr_data), .rd_en_out(rd_en), .rd_addr_out(rd_addr),
      .rd_data_in(rd_data), .rd_valid_in(rd_valid));
   // -------------------------------------------------------------------------
   // Compare and access tasks
   // -------------------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check16
   task automatic check1(input string name, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : check1
   task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp, input string name);
      logic [15:0] d;
      logic        ok;
      host_model_inst.rd_word(addr, d, ok);
      if (!ok) begin
         mismatches++;
         $display("MISMATCH %s expected valid seen none", name);
         end_of_test();
      end else begin
         check16(name, exp, d);
      end
   endtask : rd_chk
   // The gap after the tick covers the alarm edge plus the flag and pin edge.
   task automatic sample_cycle;
      @(posedge core_clk);
      #2;
      tick = 1'b1;
      @(posedge core_clk);
      #2;
      tick = 1'b0;
      repeat (3) @(posedge core_clk);
      #2;
   endtask : sample_cycle
   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge core_clk);
      #2;
      rst_n = 1'b1;
      for (int i = 0; i < 5; i++) rd_chk(regs[i], 16'h0000, "reset value");
      check1("line one oe_n", 1'b1, l1_oe_n);
      check1("line two oe_n", 1'b1, l2_oe_n);
      for (int i = 0; i < 5; i++) begin
         host_model_inst.wr_word(regs[i], 16'hFFFF);
         rd_chk(regs[i], masks[i], "masked write");
      end
      rd_chk(7'h30, 16'h0000, "unmapped");
      // Static level, filtered rate output, indicator high on line two.
      host_model_inst.wr_word(`ADDR_THR1, 16'h83E8);
      host_model_inst.wr_word(`ADDR_THR2, 16'h3830);
      host_model_inst.wr_word(`ADDR_CNT1, 16'h0000);
      host_model_inst.wr_word(`ADDR_CNT2, 16'h0000);
      host_model_inst.wr_word(`ADDR_CTRL, 16'h2217);
      rd_chk(`ADDR_DIAG, 16'h0000, "status clear");
      filt[1] = 14'h0400;
      sample_cycle();
      check1("line two level", 1'b1, l2);
      check1("line two oe_n", 1'b0, l2_oe_n);
      check1("line one oe_n", 1'b1, l1_oe_n);
      rd_chk(`ADDR_DIAG, 16'h0100, "alarm one above");
      filt[1] = 14'h2000;
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0200, "alarm two below");
      rd_chk(`ADDR_DIAG, 16'h0000, "status after read");
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0200, "status set again");
      host_model_inst.wr_word(`ADDR_CTRL, 16'h2207);
      sample_cycle();
      check1("line two unfiltered", 1'b0, l2);
      rd_chk(`ADDR_DIAG, 16'h0000, "unfiltered status");
      // Active low indicator on line one.
      host_model_inst.wr_word(`ADDR_CTRL, 16'h2214);
      sample_cycle();
      check1("line one level", 1'b0, l1);
      check1("line one oe_n", 1'b0, l1_oe_n);
      check1("line two oe_n", 1'b1, l2_oe_n);
      // Disabling both sources empties the rate history; the old flag must survive.
      host_model_inst.wr_word(`ADDR_CTRL, 16'h0000);
      sample_cycle();
      check1("line one released", 1'b1, l1_oe_n);
      check1("line two released", 1'b1, l2_oe_n);
      rd_chk(`ADDR_DIAG, 16'h0200, "sticky while disabled");
      // Rate of change over two samples on alarm one, unfiltered.
      host_model_inst.wr_word(`ADDR_THR1, 16'h8010);
      host_model_inst.wr_word(`ADDR_CNT1, 16'h0002);
      host_model_inst.wr_word(`ADDR_CTRL, 16'h0A00);
      raw[1] = 14'h0000;
      repeat (3) sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0000, "rate flat");
      raw[1] = 14'h0100;
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0100, "rate step");
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0100, "rate window two");
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0000, "rate settled");
      // Every source code on alarm two, all sources above a zero threshold.
      raw = {4{14'h0005}};
      host_model_inst.wr_word(`ADDR_THR2, 16'h8000);
      for (int c = 0; c < 8; c++) begin
         host_model_inst.wr_word(`ADDR_CTRL, {1'b0, c[2:0], 12'h000});
         sample_cycle();
         rd_chk(`ADDR_DIAG, (c inside {1, 2, 5, 6}) ? 16'h0200 : 16'h0000, "source code");
      end
      // Rate of change on alarm two from the supply, count left at zero.
      host_model_inst.wr_word(`ADDR_THR2, 16'h8010);
      host_model_inst.wr_word(`ADDR_CTRL, 16'h9000);
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0000, "rate two first sample");
      raw[0] = 14'h0105;
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0200, "rate two step");
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0000, "rate two flat");
      // Static below-threshold compare on an unsigned source.
      host_model_inst.wr_word(`ADDR_THR2, 16'h0010);
      host_model_inst.wr_word(`ADDR_CTRL, 16'h1000);
      raw[0] = 14'h0005;
      sample_cycle();
      rd_chk(`ADDR_DIAG, 16'h0200, "supply below");
      end_of_test();
   end
endmodule : tb_top
